// ---- include/scsp_pkg.sv ----
/*
  Shared constants and types of the sensor control serial port.
  Assumes the serial port and the sequencer are built from these names only.
*/
package scsp_pkg;
  // Serial frame layout: control bit, 7 address bits, 8 data bits.
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam int REG_COUNT = 128;
  localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
  localparam logic [3:0] DATA_FIRST_BIT = 4'h8;

  // Register offsets.
  localparam logic [6:0] REG_FRAME_COUNT_LOW = 7'h46;
  localparam logic [6:0] REG_FRAME_COUNT_HIGH = 7'h47;
  localparam logic [6:0] REG_FRAME_OVERHEAD_LENGTH = 7'h49;
  localparam logic [6:0] REG_TEMPERATURE_LOW = 7'h7e;
  localparam logic [6:0] REG_TEMPERATURE_HIGH = 7'h7f;

  // Reset values; every other register resets to zero.
  localparam logic [7:0] RST_FRAME_COUNT_LOW = 8'h01;
  localparam logic [7:0] RST_FRAME_OVERHEAD_LENGTH = 8'h0a;
  localparam logic [7:0] RST_OTHER = 8'h00;

  // Sequencer timing in master clock periods.
  localparam int LINE_CYCLES = 129;
  localparam int OVERHEAD_LANE_FACTOR = 2;
  localparam int MAX_OUTPUTS = 16;
  localparam int EXPOSURE_START_DELAY = 133;
  localparam int TIMER_W = 32;

  // One complete serial frame as captured by the port.
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } scsp_frame_s;

  // Sequencer phases.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_EXPOSE = 2'b01,
    SEQ_OVERHEAD = 2'b10,
    SEQ_READOUT = 2'b11
  } scsp_state_e;
endpackage

// ---- core/scsp_sync.sv ----
/*
  Three flip-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; the output follows once stages two and three agree.
*/
`timescale 1ns/1ps
module scsp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Levels in and out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] mid_reg;
  logic [WIDTH-1:0] late_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  // A bit moves only when stages two and three agree, which filters a single odd sample.
  assign stable_next = (mid_reg & late_reg) | (stable_reg & (mid_reg ^ late_reg));
  assign o_sync = stable_reg;

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= '0;
      mid_reg <= '0;
      late_reg <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg <= i_async;
      mid_reg <= meta_reg;
      late_reg <= mid_reg;
      stable_reg <= stable_next;
    end
  end
endmodule

// ---- core/scsp_serial.sv ----
/*
  Serial register port, clocked by the host's serial clock.
  Assumes the register file answers i_read_data for o_read_addr and holds it steady during a read.
*/
`timescale 1ns/1ps
module scsp_serial (
  // Serial clock domain
  input wire logic i_serial_clock,
  input wire logic i_arst_n,
  // Serial pins
  input wire logic i_serial_enable,
  input wire logic i_serial_in,
  output logic o_serial_out,
  // Toward the register file
  output scsp_pkg::scsp_frame_s o_frame,
  output logic o_commit_toggle,
  output logic [scsp_pkg::ADDR_W-1:0] o_read_addr,
  input wire logic [scsp_pkg::DATA_W-1:0] i_read_data
);
  logic [scsp_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
  logic [14:0] shift_reg;
  logic read_mode_reg;
  logic pending_reg;
  logic commit_toggle_reg;
  logic serial_out_reg;
  scsp_pkg::scsp_frame_s frame_reg;
  logic [15:0] word_in;
  logic addr_done;
  logic frame_done;
  logic read_phase;

  assign word_in = {shift_reg, i_serial_in};
  assign addr_done = bit_cnt_reg == scsp_pkg::ADDR_LAST_BIT;
  assign frame_done = bit_cnt_reg == scsp_pkg::FRAME_LAST_BIT;
  assign read_phase = i_serial_enable && read_mode_reg && bit_cnt_reg >= scsp_pkg::DATA_FIRST_BIT;
  assign o_frame = frame_reg;
  assign o_commit_toggle = commit_toggle_reg;
  assign o_serial_out = serial_out_reg;

  // Bits are taken on rising edges; dropping the enable discards a partial frame.
  always_ff @(posedge i_serial_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      read_mode_reg <= 1'b0;
      pending_reg <= 1'b0;
      o_read_addr <= '0;
      frame_reg <= '0;
    end else if (!i_serial_enable) begin
      bit_cnt_reg <= '0;
      read_mode_reg <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      shift_reg <= word_in[14:0];
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      pending_reg <= frame_done && word_in[15];
      if (addr_done) begin
        o_read_addr <= word_in[6:0];
        read_mode_reg <= !word_in[7];
      end
      if (frame_done) begin
        frame_reg <= word_in;
      end
    end
  end

  // Falling edges commit a finished write and launch read data, MSB first.
  always_ff @(negedge i_serial_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      commit_toggle_reg <= 1'b0;
      serial_out_reg <= 1'b0;
    end else begin
      if (pending_reg) begin
        commit_toggle_reg <= !commit_toggle_reg;
      end
      serial_out_reg <= read_phase && i_read_data[~bit_cnt_reg[2:0]];
    end
  end
endmodule

// ---- core/scsp_top.sv ----
/*
  Control side of the image sensor: register file, serial port and frame sequencer.
  Assumes i_clock is the master clock and the serial clock comes from the host.
  Host pins reach the master domain through the three stage synchroniser.
*/
// Function
// - Serial input sampled on rising serial clock.
// - Frame is sixteen bits: control, address, data.
// - Control bit one writes, zero reads.
// - Seven address bits follow, MSB first.
// - Write carries eight data bits, MSB first.
// - Bursts send frames back to back.
// - Read data driven MSB first on falling edges.
// - Registers 78-79 writable without disturbing imaging.
// - Reset falling edge clears sequencer and registers.
// - Request captures the programmed frame count.
// - Overhead lasts (length + 32/outputs) * 129.
// - Reset and request sampled on master clock.
`timescale 1ns/1ps
module scsp_top #(
  parameter int OUTPUTS = 16,
  parameter int READOUT_LINES = 1088,
  parameter int EXPOSURE_CYCLES = 4800
) (
  // Master clock and board reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Host control pins, asynchronous to the master clock
  input wire logic i_system_reset_n,
  input wire logic i_frame_request,
  // Serial register port, clocked by the host
  input wire logic i_serial_clock,
  input wire logic i_serial_enable,
  input wire logic i_serial_in,
  output logic o_serial_out,
  // On-chip temperature reading, master clock domain
  input wire logic [15:0] i_temperature,
  // Sequencer status
  output logic o_busy,
  output logic o_exposing,
  output logic o_overhead,
  output logic o_readout
);
  // Synchronised pin bit positions.
  localparam int SYNC_RESET = 0;
  localparam int SYNC_REQUEST = 1;
  localparam int SYNC_ENABLE = 2;
  localparam int SYNC_COMMIT = 3;
  localparam int SYNC_W = 4;
  localparam logic [31:0] TIMER_ONE = 32'h0000_0001;

  // Default value of one register.
  function automatic logic [scsp_pkg::DATA_W-1:0] reset_value(input logic [scsp_pkg::ADDR_W-1:0] addr);
    logic [scsp_pkg::DATA_W-1:0] value;
    value = scsp_pkg::RST_OTHER;
    if (addr == scsp_pkg::REG_FRAME_COUNT_LOW) begin
      value = scsp_pkg::RST_FRAME_COUNT_LOW;
    end else if (addr == scsp_pkg::REG_FRAME_OVERHEAD_LENGTH) begin
      value = scsp_pkg::RST_FRAME_OVERHEAD_LENGTH;
    end
    return value;
  endfunction

  // Registers that the host may not change.
  function automatic logic read_only(input logic [scsp_pkg::ADDR_W-1:0] addr);
    return addr == scsp_pkg::REG_TEMPERATURE_LOW || addr == scsp_pkg::REG_TEMPERATURE_HIGH;
  endfunction

  // Overhead length in master cycles for a given length field.
  function automatic logic [31:0] overhead_cycles(input logic [scsp_pkg::DATA_W-1:0] length);
    logic [31:0] lanes;
    lanes = 32'(scsp_pkg::OVERHEAD_LANE_FACTOR * scsp_pkg::MAX_OUTPUTS / OUTPUTS);
    return (32'(length) + lanes) * 32'(scsp_pkg::LINE_CYCLES);
  endfunction

  // Fixed phase lengths, loaded into the timer minus one.
  localparam logic [31:0] EXPOSE_LOAD = 32'(scsp_pkg::EXPOSURE_START_DELAY + EXPOSURE_CYCLES - 1);
  localparam logic [31:0] READOUT_LOAD =
    32'(scsp_pkg::LINE_CYCLES * (scsp_pkg::MAX_OUTPUTS / OUTPUTS) * READOUT_LINES - 1);

  // Register file, frame sequencer and crossing state.
  logic [scsp_pkg::DATA_W-1:0] reg_file_reg [scsp_pkg::REG_COUNT];
  logic [scsp_pkg::DATA_W-1:0] temp_low_reg;
  logic [scsp_pkg::DATA_W-1:0] temp_high_reg;
  scsp_pkg::scsp_state_e state_reg;
  scsp_pkg::scsp_state_e state_next;
  logic [31:0] timer_reg;
  logic [31:0] timer_next;
  logic [15:0] frames_left_reg;
  logic [15:0] frames_left_next;
  logic [scsp_pkg::DATA_W-1:0] overhead_len_reg;
  logic [scsp_pkg::DATA_W-1:0] overhead_len_next;
  logic request_seen_reg;
  logic commit_seen_reg;
  logic busy_reg;
  logic exposing_reg;
  logic overhead_reg;
  logic readout_reg;

  // Wires between the pieces.
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;
  logic system_reset_n_sync;
  logic request_sync;
  logic enable_sync;
  logic commit_sync;
  logic commit_toggle;
  logic commit_strobe;
  logic request_strobe;
  logic sequencer_clear;
  logic timer_done;
  logic write_ok;
  scsp_pkg::scsp_frame_s serial_frame;
  logic [scsp_pkg::ADDR_W-1:0] serial_read_addr;
  logic [scsp_pkg::DATA_W-1:0] serial_read_data;
  logic [15:0] frame_count;

  // Host pins and the write toggle cross into the master domain together.
  assign pins_async = {commit_toggle, i_serial_enable, i_frame_request, i_system_reset_n};

  scsp_sync #(
    .WIDTH(SYNC_W)
  ) scsp_sync_i (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_async(pins_async),
    .o_sync(pins_sync)
  );

  assign system_reset_n_sync = pins_sync[SYNC_RESET];
  assign request_sync = pins_sync[SYNC_REQUEST];
  assign enable_sync = pins_sync[SYNC_ENABLE];
  assign commit_sync = pins_sync[SYNC_COMMIT];

  // The serial port runs entirely on the host's serial clock.
  scsp_serial scsp_serial_i (
    .i_serial_clock(i_serial_clock),
    .i_arst_n(i_arst_n),
    .i_serial_enable(i_serial_enable),
    .i_serial_in(i_serial_in),
    .o_serial_out(o_serial_out),
    .o_frame(serial_frame),
    .o_commit_toggle(commit_toggle),
    .o_read_addr(serial_read_addr),
    .i_read_data(serial_read_data)
  );

  // A low system reset holds the register file and sequencer at defaults, so its falling edge always clears.
  assign sequencer_clear = !system_reset_n_sync;

  // A toggle change marks one finished write frame; the word stays put for a full frame.
  assign commit_strobe = commit_sync != commit_seen_reg;
  assign write_ok = commit_strobe && serial_frame.write && !read_only(serial_frame.addr);

  // Request acts on its rising level, so a long pulse does not start a second run.
  assign request_strobe = request_sync && !request_seen_reg;

  // Read path into the serial domain. Registers change only on committed writes, a system reset or
  // while the enable is low, so outside a system reset the byte is steady whenever the port shifts it out.
  assign serial_read_data = (serial_read_addr == scsp_pkg::REG_TEMPERATURE_LOW) ? temp_low_reg :
                            (serial_read_addr == scsp_pkg::REG_TEMPERATURE_HIGH) ? temp_high_reg :
                            reg_file_reg[serial_read_addr];

  // Frame count is a 16-bit pair.
  assign frame_count = {reg_file_reg[scsp_pkg::REG_FRAME_COUNT_HIGH],
                        reg_file_reg[scsp_pkg::REG_FRAME_COUNT_LOW]};
  assign timer_done = timer_reg == '0;

  // Edge memories for the crossing strobes.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      commit_seen_reg <= 1'b0;
      request_seen_reg <= 1'b0;
    end else begin
      commit_seen_reg <= commit_sync;
      request_seen_reg <= request_sync;
    end
  end

  // Register file; a committed write lands in one cycle at any sequencer phase.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < scsp_pkg::REG_COUNT; i++) begin
        reg_file_reg[i] <= reset_value(7'(i));
      end
    end else if (sequencer_clear) begin
      for (int i = 0; i < scsp_pkg::REG_COUNT; i++) begin
        reg_file_reg[i] <= reset_value(7'(i));
      end
    end else if (write_ok) begin
      reg_file_reg[serial_frame.addr] <= serial_frame.data;
    end
  end

  // The temperature pair is frozen while the serial enable is high, so a burst reads
  // both bytes from one sample.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      temp_low_reg <= '0;
      temp_high_reg <= '0;
    end else if (!enable_sync) begin
      temp_low_reg <= i_temperature[7:0];
      temp_high_reg <= i_temperature[15:8];
    end
  end

  // Sequencer: exposure, overhead, read-out, repeated for each programmed frame.
  // Count is latched at run start and overhead length at each overhead start, so later writes do
  // not disturb the count or the overhead in flight. Requests outside idle are ignored.
  always_comb begin
    state_next = state_reg;
    timer_next = timer_done ? timer_reg : timer_reg - TIMER_ONE;
    frames_left_next = frames_left_reg;
    overhead_len_next = overhead_len_reg;
    unique case (state_reg)
      scsp_pkg::SEQ_IDLE: begin
        if (request_strobe && frame_count != '0) begin
          state_next = scsp_pkg::SEQ_EXPOSE;
          timer_next = EXPOSE_LOAD;
          frames_left_next = frame_count;
        end
      end
      scsp_pkg::SEQ_EXPOSE: begin
        if (timer_done) begin
          state_next = scsp_pkg::SEQ_OVERHEAD;
          overhead_len_next = reg_file_reg[scsp_pkg::REG_FRAME_OVERHEAD_LENGTH];
          timer_next = overhead_cycles(reg_file_reg[scsp_pkg::REG_FRAME_OVERHEAD_LENGTH]) - TIMER_ONE;
        end
      end
      scsp_pkg::SEQ_OVERHEAD: begin
        if (timer_done) begin
          state_next = scsp_pkg::SEQ_READOUT;
          timer_next = READOUT_LOAD;
        end
      end
      scsp_pkg::SEQ_READOUT: begin
        if (timer_done) begin
          frames_left_next = frames_left_reg - 16'h0001;
          if (frames_left_reg == 16'h0001) begin
            state_next = scsp_pkg::SEQ_IDLE;
          end else begin
            state_next = scsp_pkg::SEQ_EXPOSE;
            timer_next = EXPOSE_LOAD;
          end
        end
      end
    endcase
  end

  // Sequencer state; a system reset returns it to idle at once.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= scsp_pkg::SEQ_IDLE;
      timer_reg <= '0;
      frames_left_reg <= '0;
      overhead_len_reg <= scsp_pkg::RST_FRAME_OVERHEAD_LENGTH;
    end else if (sequencer_clear) begin
      state_reg <= scsp_pkg::SEQ_IDLE;
      timer_reg <= '0;
      frames_left_reg <= '0;
      overhead_len_reg <= scsp_pkg::RST_FRAME_OVERHEAD_LENGTH;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      frames_left_reg <= frames_left_next;
      overhead_len_reg <= overhead_len_next;
    end
  end

  // Status outputs, registered from the next state so they line up with the phase.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_reg <= 1'b0;
      exposing_reg <= 1'b0;
      overhead_reg <= 1'b0;
      readout_reg <= 1'b0;
    end else begin
      busy_reg <= !sequencer_clear && state_next != scsp_pkg::SEQ_IDLE;
      exposing_reg <= !sequencer_clear && state_next == scsp_pkg::SEQ_EXPOSE;
      overhead_reg <= !sequencer_clear && state_next == scsp_pkg::SEQ_OVERHEAD;
      readout_reg <= !sequencer_clear && state_next == scsp_pkg::SEQ_READOUT;
    end
  end

  assign o_busy = busy_reg;
  assign o_exposing = exposing_reg;
  assign o_overhead = overhead_reg;
  assign o_readout = readout_reg;
endmodule

// ---- testbench/scsp_assertions.sv ----
/*
  Concurrent checks on the sensor control serial port top.
  Assumes it is bound to scsp_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module scsp_checker #(
  parameter int OUTPUTS = 16,
  parameter int READOUT_LINES = 1088,
  parameter int EXPOSURE_CYCLES = 4800
) (
  // Watched ports
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_system_reset_n,
  input wire logic i_frame_request,
  input wire logic i_serial_clock,
  input wire logic i_serial_enable,
  input wire logic i_serial_in,
  input wire logic o_serial_out,
  input wire logic [15:0] i_temperature,
  input wire logic o_busy,
  input wire logic o_exposing,
  input wire logic o_overhead,
  input wire logic o_readout
);
  localparam int EXP_LEN = scsp_pkg::EXPOSURE_START_DELAY + EXPOSURE_CYCLES;
  localparam int OVH_MIN = scsp_pkg::OVERHEAD_LANE_FACTOR * scsp_pkg::MAX_OUTPUTS / OUTPUTS * scsp_pkg::LINE_CYCLES;
  localparam int RDO_LEN = scsp_pkg::LINE_CYCLES * (scsp_pkg::MAX_OUTPUTS / OUTPUTS) * READOUT_LINES;
  logic [31:0] exp_cnt_reg;
  logic [31:0] ovh_cnt_reg;
  logic [31:0] rdo_cnt_reg;

  // Phases run far past any repetition bound, so their lengths are counted here.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      exp_cnt_reg <= 32'h0000_0000;
      ovh_cnt_reg <= 32'h0000_0000;
      rdo_cnt_reg <= 32'h0000_0000;
    end else begin
      exp_cnt_reg <= o_exposing ? exp_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
      ovh_cnt_reg <= o_overhead ? ovh_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
      rdo_cnt_reg <= o_readout ? rdo_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // Sequencer checks; a host system reset may cut a phase short, so it disables the length and start checks.
  chk_phase_busy_agree: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $onehot0({o_exposing, o_overhead, o_readout}) && (o_busy == (o_exposing | o_overhead | o_readout)))
    else $error("Phase outputs disagree with busy.");
  chk_expose_length: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_system_reset_n)
    $fell(o_exposing) |-> exp_cnt_reg == 32'(EXP_LEN) && o_overhead)
    else $error("Exposure length or successor wrong.");
  chk_overhead_length: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_system_reset_n)
    $fell(o_overhead) |-> ovh_cnt_reg >= 32'(OVH_MIN) && o_readout)
    else $error("Overhead too short or not followed by read-out.");
  chk_readout_length: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_system_reset_n)
    $fell(o_readout) |-> rdo_cnt_reg == 32'(RDO_LEN) && (o_exposing || !o_busy))
    else $error("Read-out length or successor wrong.");
  chk_start_cause: assert property (@(posedge i_clock) disable iff (!i_arst_n || !i_system_reset_n)
    $rose(o_busy) |-> o_exposing && $past(i_frame_request, 4))
    else $error("Run started without a frame request.");
  chk_reset_clears: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $fell(i_system_reset_n) |-> ##[1:8] !o_busy)
    else $error("System reset did not stop the sequencer.");
  chk_reset_holds: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!i_system_reset_n)[*8] |-> !o_busy && !o_exposing)
    else $error("Sequencer active while system reset held.");
  chk_sout_idle: assert property (@(posedge i_serial_clock) disable iff (!i_arst_n)
    !i_serial_enable |-> !o_serial_out)
    else $error("Serial output not low outside a transfer.");
endmodule

bind scsp_top scsp_checker #(
  .OUTPUTS(OUTPUTS), .READOUT_LINES(READOUT_LINES), .EXPOSURE_CYCLES(EXPOSURE_CYCLES)
) scsp_checker_i (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_system_reset_n(i_system_reset_n),
  .i_frame_request(i_frame_request), .i_serial_clock(i_serial_clock), .i_serial_enable(i_serial_enable),
  .i_serial_in(i_serial_in), .o_serial_out(o_serial_out), .i_temperature(i_temperature),
  .o_busy(o_busy), .o_exposing(o_exposing), .o_overhead(o_overhead), .o_readout(o_readout)
);

// ---- testbench/scsp_host_model.sv ----
/*
  Behavioural host controller driving the serial register port.
  Assumes the caller passes whole 16-bit words; cut may end a transfer early on purpose.
*/
`timescale 1ns/1ps
module scsp_host_model (
  // Serial pins toward the device
  output logic o_serial_clock,
  output logic o_serial_enable,
  output logic o_serial_in,
  input wire logic i_serial_out
);
  localparam time HALF = 24; // 48 ns period keeps the clock under 48 MHz.

  // The serial clock stands still between transfers.
  initial begin
    o_serial_clock = 1'b0;
    o_serial_enable = 1'b0;
    o_serial_in = 1'b0;
  end

  // Sends n frames back to back under one enable, stopping after cut bits.
  task automatic burst(input int n, input int cut, input logic [15:0] w [4], output logic [7:0] rd [4]);
    int i;
    rd = '{default: 8'h00};
    #7;
    o_serial_enable = 1'b1;
    #HALF;
    for (i = 0; i < n * 16 && i < cut; i++) begin
      o_serial_in = w[i / 16][15 - i % 16];
      #HALF;
      o_serial_clock = 1'b1;
      if (i % 16 >= 8) rd[i / 16] = {rd[i / 16][6:0], i_serial_out};
      #HALF;
      o_serial_clock = 1'b0;
    end
    o_serial_in = ~o_serial_in;
    #(2 * HALF);
    o_serial_enable = 1'b0;
    #HALF;
    o_serial_clock = 1'b1;
    #HALF;
    o_serial_clock = 1'b0;
  endtask
endmodule

// ---- testbench/sensor_control_serial_port_tb.sv ----
/*
  Self-checking bench for the sensor control serial port.
  Assumes the host model drives the serial pins and the checker is bound to the top.
*/
`timescale 1ns/1ps
module sensor_control_serial_port_tb;
  localparam int EXP_LEN = scsp_pkg::EXPOSURE_START_DELAY + 4;
  localparam int LINE = scsp_pkg::LINE_CYCLES;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_system_reset_n = 1'b1;
  logic i_frame_request = 1'b0;
  logic [15:0] i_temperature = 16'h5ac3;
  logic serial_clock, serial_enable, serial_in, serial_out;
  logic o_busy, o_exposing, o_overhead, o_readout;
  logic [7:0] rd [4];
  int failures = 0;
  int samples_checked = 0;
  int exp_cycles, ovh_cycles, rdo_cycles, ovh_starts;

  always #10 i_clock = ~i_clock;

  // Short exposure and one line keep each frame near 524 cycles.
  scsp_top #(.OUTPUTS(16), .READOUT_LINES(1), .EXPOSURE_CYCLES(4)) scsp_top_i (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_system_reset_n(i_system_reset_n),
    .i_frame_request(i_frame_request), .i_serial_clock(serial_clock), .i_serial_enable(serial_enable),
    .i_serial_in(serial_in), .o_serial_out(serial_out), .i_temperature(i_temperature),
    .o_busy(o_busy), .o_exposing(o_exposing), .o_overhead(o_overhead), .o_readout(o_readout)
  );
  scsp_host_model scsp_host_model_i (
    .o_serial_clock(serial_clock), .o_serial_enable(serial_enable),
    .o_serial_in(serial_in), .i_serial_out(serial_out)
  );

  // Phase lengths are gathered here so a whole run can be judged afterwards.
  always @(posedge i_clock) begin
    if (o_exposing === 1'b1) exp_cycles++;
    if (o_overhead === 1'b1) ovh_cycles++;
    if (o_readout === 1'b1) rdo_cycles++;
    if ($rose(o_overhead)) ovh_starts++;
  end

  function automatic logic [15:0] wr(input logic [6:0] a, input logic [7:0] d);
    return {1'b1, a, d};
  endfunction
  function automatic logic [15:0] rq(input logic [6:0] a);
    return {1'b0, a, 8'h00};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Bounded wait for busy; running out ends the run as a failure.
  task automatic wait_busy(input logic val, input int bound);
    int n;
    n = 0;
    while (o_busy !== val && n < bound) begin
      tick(1);
      n++;
    end
    if (o_busy !== val) begin
      failures++;
      $display("BAD %0t busy wait ran out", $time);
      print_verdict();
    end
  endtask

  // The request is held ten cycles so the synchroniser cannot miss it.
  task automatic request();
    tick(1);
    i_frame_request = 1'b1;
    tick(10);
    i_frame_request = 1'b0;
  endtask

  task automatic t_reset_values();
    scsp_host_model_i.burst(4, 64, '{rq(7'h46), rq(7'h47), rq(7'h49), rq(7'h10)}, rd);
    check(rd[0], 8'h01, "frame count low default");
    check(rd[1], 8'h00, "frame count high default");
    check(rd[2], 8'h0a, "overhead length default");
    check(rd[3], 8'h00, "plain register default");
  endtask

  task automatic t_write_burst();
    // All but the write to read-only 7e land while the sensor is idle, including the overhead-only register 40.
    scsp_host_model_i.burst(4, 64, '{wr(7'h4e, 8'ha5), wr(7'h05, 8'h3c), wr(7'h7e, 8'hff),
                                     wr(7'h28, 8'h96)}, rd);
    // The reading changes mid-burst; both bytes must still come from the earlier sample.
    fork
      scsp_host_model_i.burst(4, 64, '{rq(7'h4e), rq(7'h05), rq(7'h7e), rq(7'h7f)}, rd);
      begin
        tick(20);
        i_temperature = 16'h3c5a;
      end
    join
    check(rd[0], 8'ha5, "register 78 write");
    check(rd[1], 8'h3c, "register 5 write");
    check(rd[2], 8'hc3, "temperature low");
    check(rd[3], 8'h5a, "temperature high");
  endtask

  task automatic t_abort();
    scsp_host_model_i.burst(1, 15, '{wr(7'h05, 8'h77), 16'h0000, 16'h0000, 16'h0000}, rd);
    scsp_host_model_i.burst(1, 16, '{rq(7'h05), 16'h0000, 16'h0000, 16'h0000}, rd);
    check(rd[0], 8'h3c, "short frame was stored");
  endtask

  task automatic t_count_zero();
    scsp_host_model_i.burst(1, 16, '{wr(7'h46, 8'h00), 16'h0000, 16'h0000, 16'h0000}, rd);
    request();
    tick(40);
    check(o_busy, 1'b0, "zero frame count started a run");
  endtask

  task automatic t_frames();
    scsp_host_model_i.burst(2, 32, '{wr(7'h46, 8'h02), wr(7'h49, 8'h00), 16'h0000, 16'h0000}, rd);
    tick(10);
    exp_cycles = 0;
    ovh_cycles = 0;
    rdo_cycles = 0;
    ovh_starts = 0;
    request();
    wait_busy(1'b1, 20);
    scsp_host_model_i.burst(1, 16, '{wr(7'h4f, 8'h5a), 16'h0000, 16'h0000, 16'h0000}, rd);
    wait_busy(1'b0, 2000);
    check(ovh_starts, 2, "frames per request");
    check(exp_cycles, 2 * EXP_LEN, "exposure cycles");
    check(ovh_cycles, 2 * 2 * LINE, "overhead cycles");
    check(rdo_cycles, 2 * LINE, "read-out cycles");
    scsp_host_model_i.burst(1, 16, '{rq(7'h4f), 16'h0000, 16'h0000, 16'h0000}, rd);
    check(rd[0], 8'h5a, "register 79 write during run");
  endtask

  task automatic t_sys_reset();
    scsp_host_model_i.burst(1, 16, '{wr(7'h49, 8'h33), 16'h0000, 16'h0000, 16'h0000}, rd);
    request();
    wait_busy(1'b1, 20);
    i_system_reset_n = 1'b0;
    tick(10);
    check(o_busy, 1'b0, "system reset left sequencer busy");
    i_system_reset_n = 1'b1;
    // No gain is changed here, so the 1.2us gap is all the settling that is due.
    tick(60);
    scsp_host_model_i.burst(4, 64, '{rq(7'h49), rq(7'h46), rq(7'h4e), rq(7'h28)}, rd);
    check(rd[0], 8'h0a, "overhead length after reset");
    check(rd[1], 8'h01, "frame count after reset");
    check(rd[2], 8'h00, "register 78 after reset");
    check(rd[3], 8'h00, "register 40 after reset");
  endtask

  // Main sequence; the wait after reset release covers the start-up gap.
  initial begin
    tick(20);
    i_arst_n = 1'b1;
    tick(60);
    t_reset_values();
    t_write_burst();
    t_abort();
    t_count_zero();
    t_frames();
    t_sys_reset();
    print_verdict();
  end
endmodule
